// ==== rtl/pcl_pkg.sv ====
// Package: register map, control field positions, reset values and bus carriers for the control-line block
package pcl_pkg;
  // Register select codes on the 2-bit select lines
  localparam logic [1:0] SEL_PORT_A_DATA = 2'h0;
  localparam logic [1:0] SEL_PORT_A_CTRL = 2'h1;
  localparam logic [1:0] SEL_PORT_B_DATA = 2'h2;
  localparam logic [1:0] SEL_PORT_B_CTRL = 2'h3;

  // Control register field positions
  localparam int CTL_IN_IRQ_EN = 0;
  localparam int CTL_IN_EDGE = 1;
  localparam int CTL_DATA_SEL = 2;
  localparam int CTL_IO_B3 = 3;
  localparam int CTL_IO_B4 = 4;
  localparam int CTL_IO_OUT = 5;
  localparam int CTL_IO_FLAG = 6;
  localparam int CTL_IN_FLAG = 7;
  localparam int CTL_WR_LSB = 0;
  localparam int CTL_WR_MSB = 5;

  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Host bus request, sampled on the processor clock
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [1:0] rs;
    logic [7:0] wdata;
  } pcl_bus_s;

  // Decoded per-port access strobes
  typedef struct packed {
    logic data_rd;
    logic data_wr;
    logic ctrl_wr;
  } pcl_acc_s;
endpackage

// ==== rtl/pcl_port.sv ====
// One port's control register, interrupt flags and control-line logic
`timescale 1ns/1ns
module pcl_port #(
  parameter bit WRITE_HANDSHAKE = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register access
  input wire pcl_pkg::pcl_acc_s acc,
  input wire logic [7:0] wdata,
  output logic [7:0] ctrl_rdata,
  // Synchronised control lines
  input wire logic in_sync,
  input wire logic io_sync,
  // Line outputs
  output logic io_out,
  output logic io_oe,
  output logic irq_n
);

  logic [5:0] ctrl_r;
  logic in_flag_r;
  logic io_flag_r;
  logic in_prev_r;
  logic io_prev_r;
  logic hs_r;
  logic pulse_r;
  logic in_edge;
  logic io_edge;
  logic io_is_out;
  logic trigger;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on consecutive samples; held high in reset to match the idle level of the lines
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_prev_r <= 1'b1;
      io_prev_r <= 1'b1;
    end else begin
      in_prev_r <= in_sync; // see R17
      io_prev_r <= io_sync;
    end
  end

  assign in_edge = ctrl_r[pcl_pkg::CTL_IN_EDGE] ? (in_sync & ~in_prev_r) : (~in_sync & in_prev_r); // see R14
  assign io_is_out = ctrl_r[pcl_pkg::CTL_IO_OUT];
  assign io_edge = !io_is_out &&
                   (ctrl_r[pcl_pkg::CTL_IO_B4] ? (io_sync & ~io_prev_r) : (~io_sync & io_prev_r)); // see R5
  // Port B keys output modes off data writes, port A off data reads
  assign trigger = WRITE_HANDSHAKE ? acc.data_wr : acc.data_rd; // see R8

  //////////////////////////////////////////////////////////////////////////////
  // Control register, writable bits 5..0
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= pcl_pkg::CTL_RESET;
    end else if (acc.ctrl_wr) begin
      ctrl_r <= wdata[pcl_pkg::CTL_WR_MSB:pcl_pkg::CTL_WR_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags: set regardless of enable; an edge in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_flag_r <= 1'b0;
    end else if (in_edge) begin
      in_flag_r <= 1'b1; // see R3 see R2
    end else if (acc.data_rd) begin
      in_flag_r <= 1'b0; // see R16
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_flag_r <= 1'b0;
    end else if (io_edge) begin
      io_flag_r <= 1'b1; // see R5 see R7
    end else if (acc.data_rd || io_is_out) begin
      io_flag_r <= 1'b0; // see R16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output modes of the second line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= 1'b1;
    end else if (trigger) begin
      hs_r <= 1'b0; // see R9 see R11
    end else if (in_edge) begin
      hs_r <= 1'b1; // see R9 see R11
    end
  end

  // Pulse is one clock low after the access, since the access strobe is itself one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_r <= 1'b1;
    end else begin
      pulse_r <= ~trigger; // see R10 see R12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_out <= 1'b1;
      io_oe <= 1'b0;
    end else begin
      io_oe <= io_is_out;
      if (!io_is_out) begin
        io_out <= 1'b1;
      end else if (ctrl_r[pcl_pkg::CTL_IO_B4]) begin
        io_out <= ctrl_r[pcl_pkg::CTL_IO_B3]; // see R15
      end else if (ctrl_r[pcl_pkg::CTL_IO_B3]) begin
        io_out <= ~trigger; // see R10 see R12
      end else if (trigger) begin
        io_out <= 1'b0;
      end else begin
        io_out <= in_edge | hs_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt output, registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~((in_flag_r & ctrl_r[pcl_pkg::CTL_IN_IRQ_EN]) |
                 (io_flag_r & ~io_is_out & ctrl_r[pcl_pkg::CTL_IO_B3])); // see R4 see R6
    end
  end

  assign ctrl_rdata = {in_flag_r, io_flag_r, ctrl_r};

endmodule

// ==== rtl/pcl_top.sv ====
// Control-line and interrupt logic of a two-port interface adapter, with host register access
`timescale 1ns/1ns
// Notes on behaviour
// R1: First control line of each port is only an interrupt input, never driven.
// R2: Port B input flag bit 7 sets on its first line's active transition.
// R3: Flag bit 7 sets on an active edge regardless of enable bit 0.
// R4: Interrupt output low while bit 7 and enable bit 0 are both set.
// R5: Bit 5 low makes second line an input; bit 4 picks edge; sets bit 6.
// R6: In input mode, interrupt low when bit 6 set and bit 3 set.
// R7: Port B second line input modes mirror port A exactly.
// R8: Port B output modes key off data writes instead of reads.
// R9: Port A handshake: high on first-line edge, low on data read.
// R10: Port A pulse mode: one cycle low after each data read.
// R11: Port B handshake: low on data write, high on first-line edge.
// R12: Port B pulse mode: one cycle low after each data write.
// R13: Two separate interrupt outputs, one per port.
// R14: First line edge negative when bit 1 is 0, positive when 1.
// R15: Bits 5 and 4 set make second line a manual output following bit 3.
// R16: Reading a port's data register clears both its flags.
// R17: Inputs sampled on the clock; edges from consecutive samples; pulses in clocks.
// R18: Peripheral holds each control-line level at least one full clock; the input filter here needs each level sampled on two consecutive clocks.
module pcl_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host bus
  input wire logic [2:0] chip_select_lines,
  input wire logic [1:0] register_select_lines,
  input wire logic rd_wr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Port data registers towards the data-port logic
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_a_out_reg,
  output logic [7:0] port_b_out_reg,
  // Control lines
  input wire logic port_a_ctl_in,
  input wire logic port_b_ctl_in,
  input wire logic port_a_ctl_io_i,
  output logic port_a_ctl_io_o,
  output logic port_a_ctl_io_oe,
  input wire logic port_b_ctl_io_i,
  output logic port_b_ctl_io_o,
  output logic port_b_ctl_io_oe,
  // Interrupts
  output logic port_a_irq_n,
  output logic port_b_irq_n
);

  logic [2:0] sync_a_in_r;
  logic [2:0] sync_b_in_r;
  logic [2:0] sync_a_io_r;
  logic [2:0] sync_b_io_r;
  logic a_in_q;
  logic b_in_q;
  logic a_io_q;
  logic b_io_q;
  logic sel_prev_r;
  pcl_pkg::pcl_bus_s bus;
  pcl_pkg::pcl_acc_s acc_a;
  pcl_pkg::pcl_acc_s acc_b;
  logic [7:0] ctrl_a_rdata;
  logic [7:0] ctrl_b_rdata;
  logic [7:0] rdata_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Three-stage pin synchronisers; a level counts once stages two and three agree
  // Lines idle high, so stages reset high: a release then shows no false rising edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_in_r <= 3'h7;
      sync_b_in_r <= 3'h7;
      sync_a_io_r <= 3'h7;
      sync_b_io_r <= 3'h7;
    end else begin
      sync_a_in_r <= {sync_a_in_r[1:0], port_a_ctl_in}; // see R1 see R17
      sync_b_in_r <= {sync_b_in_r[1:0], port_b_ctl_in};
      sync_a_io_r <= {sync_a_io_r[1:0], port_a_ctl_io_i};
      sync_b_io_r <= {sync_b_io_r[1:0], port_b_ctl_io_i};
    end
  end

  // Filtered levels hold until stages agree; relies on each level being sampled on two consecutive clocks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_in_q <= 1'b1;
      b_in_q <= 1'b1;
      a_io_q <= 1'b1;
      b_io_q <= 1'b1;
    end else begin
      if (sync_a_in_r[1] == sync_a_in_r[2]) a_in_q <= sync_a_in_r[2]; // see R18
      if (sync_b_in_r[1] == sync_b_in_r[2]) b_in_q <= sync_b_in_r[2];
      if (sync_a_io_r[1] == sync_a_io_r[2]) a_io_q <= sync_a_io_r[2];
      if (sync_b_io_r[1] == sync_b_io_r[2]) b_io_q <= sync_b_io_r[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode: one access per select assertion, so a held select acts once
  assign bus.sel = chip_select_lines[0] & chip_select_lines[1] & ~chip_select_lines[2];
  assign bus.rd = bus.sel & ~sel_prev_r & rd_wr;
  assign bus.wr = bus.sel & ~sel_prev_r & ~rd_wr;
  assign bus.rs = register_select_lines;
  assign bus.wdata = data_in;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= bus.sel;
    end
  end

  assign acc_a.data_rd = bus.rd && bus.rs == pcl_pkg::SEL_PORT_A_DATA;
  assign acc_a.data_wr = bus.wr && bus.rs == pcl_pkg::SEL_PORT_A_DATA;
  assign acc_a.ctrl_wr = bus.wr && bus.rs == pcl_pkg::SEL_PORT_A_CTRL;
  assign acc_b.data_rd = bus.rd && bus.rs == pcl_pkg::SEL_PORT_B_DATA;
  assign acc_b.data_wr = bus.wr && bus.rs == pcl_pkg::SEL_PORT_B_DATA;
  assign acc_b.ctrl_wr = bus.wr && bus.rs == pcl_pkg::SEL_PORT_B_CTRL;

  //////////////////////////////////////////////////////////////////////////////
  // Output data registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_out_reg <= pcl_pkg::DATA_RESET;
      port_b_out_reg <= pcl_pkg::DATA_RESET;
    end else begin
      if (acc_a.data_wr) port_a_out_reg <= bus.wdata;
      if (acc_b.data_wr) port_b_out_reg <= bus.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, registered and held until the next read
  always_comb begin
    unique case (bus.rs)
      pcl_pkg::SEL_PORT_A_DATA: rdata_nxt = port_a_in;
      pcl_pkg::SEL_PORT_A_CTRL: rdata_nxt = ctrl_a_rdata;
      pcl_pkg::SEL_PORT_B_DATA: rdata_nxt = port_b_in;
      pcl_pkg::SEL_PORT_B_CTRL: rdata_nxt = ctrl_b_rdata;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= pcl_pkg::DATA_RESET;
      data_oe <= 1'b0;
    end else begin
      if (bus.rd) data_out <= rdata_nxt;
      data_oe <= bus.sel & rd_wr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // The two ports
  pcl_port #(
    .WRITE_HANDSHAKE(1'b0)
  ) u_port_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .acc(acc_a),
    .wdata(bus.wdata),
    .ctrl_rdata(ctrl_a_rdata),
    .in_sync(a_in_q),
    .io_sync(a_io_q),
    .io_out(port_a_ctl_io_o),
    .io_oe(port_a_ctl_io_oe),
    .irq_n(port_a_irq_n)
  ); // see R13

  pcl_port #(
    .WRITE_HANDSHAKE(1'b1)
  ) u_port_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .acc(acc_b),
    .wdata(bus.wdata),
    .ctrl_rdata(ctrl_b_rdata),
    .in_sync(b_in_q),
    .io_sync(b_io_q),
    .io_out(port_b_ctl_io_o),
    .io_oe(port_b_ctl_io_oe),
    .irq_n(port_b_irq_n)
  ); // see R2 see R7 see R8 see R13

endmodule

// ==== tb/pcl_periph.sv ====
// Peripheral-side model driving the control lines of both ports
`timescale 1ns/1ns
module pcl_periph (
  // Clock
  input wire logic ref_clk,
  // Second lines as driven by the device
  input wire logic [1:0] io_o,
  input wire logic [1:0] io_oe,
  // Lines toward the device
  output logic [1:0] ctl_in,
  output logic [1:0] io_i
);
  logic [1:0] drv = 2'h3;
  initial ctl_in = 2'h3;
  // Device drive wins where enabled
  assign io_i = (io_oe & io_o) | (~io_oe & drv);
  // Long hold so the input filter and flag path settle
  task automatic drive(input logic io, input int p, input logic v);
    @(negedge ref_clk);
    if (io) drv[p] = v;
    else ctl_in[p] = v;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// ==== tb/pcl_properties.sv ====
// Checker: control-line output modes and interrupt masking seen at the top ports
`timescale 1ns/1ns
module pcl_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host bus
  input wire logic [2:0] chip_select_lines,
  input wire logic [1:0] register_select_lines,
  input wire logic rd_wr,
  input wire logic [7:0] data_in,
  // Lines and interrupts
  input wire logic port_a_ctl_io_o,
  input wire logic port_a_ctl_io_oe,
  input wire logic port_b_ctl_io_o,
  input wire logic port_a_irq_n,
  input wire logic port_b_irq_n
);
  logic sel_r;
  logic [5:0] ca_r;
  logic [5:0] cb_r;
  logic tk;
  logic rd_a;
  logic wr_b;
  // Only the first selected edge is an access
  assign tk = chip_select_lines == 3'h3 && !sel_r;
  assign rd_a = tk && rd_wr && register_select_lines == 2'h0;
  assign wr_b = tk && !rd_wr && register_select_lines == 2'h2;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 1'b0;
    end else begin
      sel_r <= chip_select_lines == 3'h3;
    end
  end
  // Shadow of the writable control bits, so modes are known without peeking inside
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ca_r <= 6'h00;
      cb_r <= 6'h00;
    end else if (tk && !rd_wr && register_select_lines == 2'h1) begin
      ca_r <= data_in[5:0];
    end else if (tk && !rd_wr && register_select_lines == 2'h3) begin
      cb_r <= data_in[5:0];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_pulse_a;
    !port_a_ctl_io_o ##1 port_a_ctl_io_o;
  endsequence
  sequence s_pulse_b;
    !port_b_ctl_io_o ##1 port_b_ctl_io_o;
  endsequence
  // Stable shadow leaves room for one cycle of write latency
  property p_oe_a; $stable(ca_r) |-> port_a_ctl_io_oe == ca_r[5]; endproperty
  property p_man_a; $stable(ca_r) && ca_r[5:4] == 2'h3 |-> port_a_ctl_io_o == ca_r[3]; endproperty
  property p_hs_a; rd_a && ca_r[5:3] == 3'h4 |=> !port_a_ctl_io_o; endproperty
  property p_pulse_a; rd_a && ca_r[5:3] == 3'h5 |=> s_pulse_a; endproperty
  property p_hs_b; wr_b && cb_r[5:3] == 3'h4 |=> !port_b_ctl_io_o; endproperty
  property p_pulse_b; wr_b && cb_r[5:3] == 3'h5 |=> s_pulse_b; endproperty
  property p_irq_a; $stable(ca_r) && !ca_r[0] && !ca_r[3] |-> port_a_irq_n; endproperty
  property p_irq_b; $stable(cb_r) && !cb_r[0] && !cb_r[3] |-> port_b_irq_n; endproperty
  a_oe_a: assert property (p_oe_a) else $error("line enable wrong");
  a_man_a: assert property (p_man_a) else $error("manual level wrong");
  a_hs_a: assert property (p_hs_a) else $error("read handshake not low");
  a_pulse_a: assert property (p_pulse_a) else $error("read pulse wrong");
  a_hs_b: assert property (p_hs_b) else $error("write handshake not low");
  a_pulse_b: assert property (p_pulse_b) else $error("write pulse wrong");
  a_irq_a: assert property (p_irq_a) else $error("masked irq a low");
  a_irq_b: assert property (p_irq_b) else $error("masked irq b low");
endmodule
bind pcl_top pcl_properties u_props (.ref_clk, .rst_n, .chip_select_lines, .register_select_lines, .rd_wr,
  .data_in, .port_a_ctl_io_o, .port_a_ctl_io_oe, .port_b_ctl_io_o, .port_a_irq_n, .port_b_irq_n);

// ==== tb/testbench.sv ====
// Testbench: register access, control-line modes and interrupts
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cs = 3'h0;
  logic [1:0] rs = 2'h0;
  logic rw = 1'b1;
  logic [7:0] din = 8'h00;
  logic [7:0] dout;
  logic [7:0] b_out;
  logic [7:0] a_out;
  logic doe;
  logic [7:0] rv;
  logic [1:0] ci, ii, io, ioe, irq;
  int miscompares = 0;
  int checks = 0;
  pcl_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .chip_select_lines(cs), .register_select_lines(rs),
    .rd_wr(rw), .data_in(din), .data_out(dout), .data_oe(doe), .port_a_in(8'h5a), .port_b_in(8'ha5),
    .port_a_out_reg(a_out), .port_b_out_reg(b_out), .port_a_ctl_in(ci[0]), .port_b_ctl_in(ci[1]),
    .port_a_ctl_io_i(ii[0]), .port_a_ctl_io_o(io[0]), .port_a_ctl_io_oe(ioe[0]),
    .port_b_ctl_io_i(ii[1]), .port_b_ctl_io_o(io[1]), .port_b_ctl_io_oe(ioe[1]),
    .port_a_irq_n(irq[0]), .port_b_irq_n(irq[1]));
  pcl_periph pp (.ref_clk(ref_clk), .io_o(io), .io_oe(ioe), .ctl_in(ci), .io_i(ii));
  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Select for one rising edge, then drop select so the next call is a new access
  task automatic acc(input logic [1:0] r, input logic w, input logic [7:0] d);
    @(negedge ref_clk);
    cs = 3'h3;
    rs = r;
    rw = w;
    din = d;
    @(negedge ref_clk);
    rv = dout;
    cs = 3'h0;
  endtask
  task automatic tport(input int p);
    logic [1:0] d;
    logic [1:0] c;
    d = 2'(2 * p);
    c = d + 2'h1;
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'h00);
    pp.drive(1'b0, p, 1'b0);
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'h80);
    chk(irq[p], 8'h01);
    acc(c, 1'b0, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk(irq[p], 8'h00);
    acc(d, 1'b1, 8'h00);
    chk(rv, p ? 8'ha5 : 8'h5a);
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'h01);
    chk(irq[p], 8'h01);
    pp.drive(1'b0, p, 1'b1);
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'h01);
    acc(c, 1'b0, 8'h02);
    pp.drive(1'b0, p, 1'b0);
    pp.drive(1'b0, p, 1'b1);
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'h82);
    acc(c, 1'b0, 8'h08);
    pp.drive(1'b1, p, 1'b0);
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'hc8);
    chk(irq[p], 8'h00);
    acc(d, 1'b1, 8'h00);
    acc(c, 1'b0, 8'h10);
    pp.drive(1'b1, p, 1'b1);
    acc(c, 1'b1, 8'h00);
    chk(rv, 8'h50);
    chk(irq[p], 8'h01);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    chk({io, ioe, irq}, 8'h33);
    for (int p = 0; p < 2; p++) tport(p);
    acc(2'h1, 1'b0, 8'h20);
    acc(2'h0, 1'b1, 8'h00);
    chk(io[0], 8'h00);
    chk(doe, 8'h01);
    pp.drive(1'b0, 0, 1'b0);
    chk(io[0], 8'h01);
    acc(2'h3, 1'b0, 8'h20);
    acc(2'h2, 1'b0, 8'h3c);
    chk(io[1], 8'h00);
    chk(b_out, 8'h3c);
    pp.drive(1'b0, 1, 1'b0);
    chk(io[1], 8'h01);
    acc(2'h1, 1'b0, 8'h28);
    acc(2'h0, 1'b1, 8'h00);
    chk(io[0], 8'h00);
    @(negedge ref_clk);
    chk(io[0], 8'h01);
    acc(2'h3, 1'b0, 8'h28);
    acc(2'h2, 1'b1, 8'h00);
    chk(io[1], 8'h01);
    acc(2'h2, 1'b0, 8'hc3);
    chk(io[1], 8'h00);
    @(negedge ref_clk);
    chk(io[1], 8'h01);
    acc(2'h1, 1'b0, 8'h30);
    repeat (2) @(negedge ref_clk);
    chk({io[0], ioe[0]}, 8'h01);
    // Manual high on port A, manual low on port B
    acc(2'h1, 1'b0, 8'h38);
    acc(2'h3, 1'b0, 8'h30);
    repeat (2) @(negedge ref_clk);
    chk({io, ioe}, 8'h07);
    acc(2'h0, 1'b0, 8'h96);
    chk(a_out, 8'h96);
    chk(doe, 8'h00);
    stop_test();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
endmodule
